// File: src/tbpwm_top.v
/*
 * Ten-bit PWM channel with an AXI4-Lite register slave: control
 * register, duty high and duty low registers, compare buffer and
 * waveform output.
 * Assumes a shared base timer on core_clk that supplies its count,
 * two sub-count bits, its period limit and clear/match pulses.
 */
`timescale 1ns/100ps
`include "tbpwm_consts.vh"


module tbpwm_top (
  input  wire                    core_clk,
  input  wire                    reset,
  // axi4-lite write address
  input  wire                    s_axi_awvalid,
  output reg                     s_axi_awready,
  input  wire [`TBPWM_AW-1:0]    s_axi_awaddr,
  input  wire [2:0]              s_axi_awprot,
  // axi4-lite write data
  input  wire                    s_axi_wvalid,
  output reg                     s_axi_wready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  // axi4-lite write response
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  output reg  [1:0]              s_axi_bresp,
  // axi4-lite read address
  input  wire                    s_axi_arvalid,
  output reg                     s_axi_arready,
  input  wire [`TBPWM_AW-1:0]    s_axi_araddr,
  input  wire [2:0]              s_axi_arprot,
  // axi4-lite read data
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  // shared base timer
  input  wire [7:0]              base_timer,
  input  wire [1:0]              sub_count,
  input  wire [7:0]              period_limit,
  input  wire                    timer_clear,
  input  wire                    period_match,
  // channel output
  output wire                    pwm_out
);

  // address decode, used by both the write and the read path
  function [1:0] reg_sel;
    input [`TBPWM_AW-1:0] addr;
    begin
      case (addr)
        `TBPWM_OFF_CTRL: reg_sel = `TBPWM_SEL_CTRL;
        `TBPWM_OFF_DCH:  reg_sel = `TBPWM_SEL_DCH;
        `TBPWM_OFF_DCL:  reg_sel = `TBPWM_SEL_DCL;
        default:         reg_sel = `TBPWM_SEL_NONE;
      endcase
    end
  endfunction

  // response code, shared by the write and the read answer
  function [1:0] resp_code;
    input [1:0] sel;
    begin
      if (sel == `TBPWM_SEL_NONE) begin
        resp_code = `TBPWM_RESP_SLVERR;
      end else begin
        resp_code = `TBPWM_RESP_OKAY;
      end
    end
  endfunction

  // control fields
  reg                        enable_reg;
  reg                        enable_next;
  reg                        output_invert_reg;
  reg                        output_invert_next;
  // duty registers, not reset
  reg  [7:0]                 duty_high_bits_reg;
  reg  [7:0]                 duty_high_bits_next;
  reg  [1:0]                 duty_low_bits_reg;
  reg  [1:0]                 duty_low_bits_next;

  // write channel holding state
  reg                        aw_held_reg;
  reg                        aw_held_next;
  reg  [`TBPWM_AW-1:0]       aw_addr_reg;
  reg  [`TBPWM_AW-1:0]       aw_addr_next;
  reg                        w_held_reg;
  reg                        w_held_next;
  reg  [7:0]                 w_byte_reg;
  reg  [7:0]                 w_byte_next;
  reg                        w_lane_reg;
  reg                        w_lane_next;
  reg                        bvalid_next;
  reg  [1:0]                 bresp_next;
  reg                        awready_next;
  reg                        wready_next;

  // read channel state
  reg                        arready_next;
  reg                        rvalid_next;
  reg  [31:0]                rdata_next;
  reg  [1:0]                 rresp_next;
  reg  [7:0]                 rd_byte;

  wire                       aw_take;
  wire                       w_take;
  wire                       ar_take;
  wire                       do_write;
  wire [1:0]                 wr_sel;
  wire [1:0]                 rd_sel;
  wire [`TBPWM_DUTY_W-1:0]   duty_live;
  reg  [7:0]                 control_view;
  reg  [7:0]                 duty_low_view;

  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign w_take   = s_axi_wvalid && s_axi_wready;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_sel   = reg_sel(aw_addr_reg);
  assign rd_sel   = reg_sel(s_axi_araddr);

  // control register as software sees it, unimplemented bits zero
  always @* begin
    control_view                 = `TBPWM_BYTE_ZERO;
    control_view[`TBPWM_EN_BIT]  = enable_reg;
    control_view[`TBPWM_OUT_BIT] = pwm_out;
    control_view[`TBPWM_POL_BIT] = output_invert_reg;
  end

  // duty low register as software sees it
  always @* begin
    duty_low_view                              = `TBPWM_BYTE_ZERO;
    duty_low_view[`TBPWM_DCL_HI:`TBPWM_DCL_LO] = duty_low_bits_reg;
  end

  // write address and data, taken in either order
  always @* begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_byte_next  = w_byte_reg;
    w_lane_next  = w_lane_reg;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    if (aw_take) begin
      aw_held_next = `TBPWM_BIT_SET;
      aw_addr_next = s_axi_awaddr;
    end
    if (w_take) begin
      w_held_next = `TBPWM_BIT_SET;
      w_byte_next = s_axi_wdata[7:0];
      w_lane_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_next = `TBPWM_BIT_CLR;
      w_held_next  = `TBPWM_BIT_CLR;
      // both halves held: commit and answer
      bvalid_next  = `TBPWM_BIT_SET;
      bresp_next   = resp_code(wr_sel);
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = `TBPWM_BIT_CLR;
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
  end

  // register updates from a completed write
  always @* begin
    enable_next         = enable_reg;
    output_invert_next  = output_invert_reg;
    duty_high_bits_next = duty_high_bits_reg;
    duty_low_bits_next  = duty_low_bits_reg;
    if (do_write && w_lane_reg) begin
      case (wr_sel)
        `TBPWM_SEL_CTRL: begin
          enable_next        = w_byte_reg[`TBPWM_EN_BIT];
          output_invert_next = w_byte_reg[`TBPWM_POL_BIT];
        end
        `TBPWM_SEL_DCH: begin
          duty_high_bits_next = w_byte_reg;
        end
        `TBPWM_SEL_DCL: begin
          duty_low_bits_next = w_byte_reg[`TBPWM_DCL_HI:`TBPWM_DCL_LO];
        end
        default: begin
          enable_next = enable_reg;
        end
      endcase
    end
  end

  // read path
  always @* begin
    case (rd_sel)
      `TBPWM_SEL_CTRL: rd_byte = control_view;
      `TBPWM_SEL_DCH:  rd_byte = duty_high_bits_reg;
      `TBPWM_SEL_DCL:  rd_byte = duty_low_view;
      default:         rd_byte = `TBPWM_BYTE_ZERO;
    endcase
    arready_next = s_axi_arready;
    rvalid_next  = s_axi_rvalid;
    rdata_next   = s_axi_rdata;
    rresp_next   = s_axi_rresp;
    if (ar_take) begin
      arready_next = `TBPWM_BIT_CLR;
      rvalid_next  = `TBPWM_BIT_SET;
      rdata_next   = {`TBPWM_PAD, rd_byte};
      rresp_next   = resp_code(rd_sel);
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next  = `TBPWM_BIT_CLR;
      arready_next = `TBPWM_BIT_SET;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      aw_held_reg       <= `TBPWM_BIT_CLR;
      aw_addr_reg       <= `TBPWM_OFF_CTRL;
      w_held_reg        <= `TBPWM_BIT_CLR;
      w_byte_reg        <= `TBPWM_BYTE_ZERO;
      w_lane_reg        <= `TBPWM_BIT_CLR;
      s_axi_awready     <= `TBPWM_BIT_CLR;
      s_axi_wready      <= `TBPWM_BIT_CLR;
      s_axi_bvalid      <= `TBPWM_BIT_CLR;
      s_axi_bresp       <= `TBPWM_RESP_OKAY;
      s_axi_arready     <= `TBPWM_BIT_CLR;
      s_axi_rvalid      <= `TBPWM_BIT_CLR;
      s_axi_rdata       <= `TBPWM_WORD_ZERO;
      s_axi_rresp       <= `TBPWM_RESP_OKAY;
    end else begin
      aw_held_reg       <= aw_held_next;
      aw_addr_reg       <= aw_addr_next;
      w_held_reg        <= w_held_next;
      w_byte_reg        <= w_byte_next;
      w_lane_reg        <= w_lane_next;
      s_axi_awready     <= awready_next;
      s_axi_wready      <= wready_next;
      s_axi_bvalid      <= bvalid_next;
      s_axi_bresp       <= bresp_next;
      // ready again once idle with no read pending
      s_axi_arready     <= arready_next || (!rvalid_next && !ar_take);
      s_axi_rvalid      <= rvalid_next;
      s_axi_rdata       <= rdata_next;
      s_axi_rresp       <= rresp_next;
    end
  end

  // control fields, cleared by every reset
  always @(posedge core_clk) begin
    if (reset) begin
      enable_reg        <= `TBPWM_BIT_CLR;
      output_invert_reg <= `TBPWM_BIT_CLR;
    end else begin
      enable_reg        <= enable_next;
      output_invert_reg <= output_invert_next;
    end
  end

  // duty bits survive reset
  always @(posedge core_clk) begin
    duty_high_bits_reg <= duty_high_bits_next;
    duty_low_bits_reg  <= duty_low_bits_next;
  end

  tbpwm_dbuf tbpwm_dbuf_i (
    .core_clk     (core_clk),
    .duty_high    (duty_high_bits_reg),
    .duty_low     (duty_low_bits_reg),
    .period_match (period_match),
    .duty_live    (duty_live)
  );

  tbpwm_wave tbpwm_wave_i (
    .core_clk     (core_clk),
    .reset        (reset),
    .enable       (enable_reg),
    .invert       (output_invert_reg),
    .timer_clear  (timer_clear),
    .base_timer   (base_timer),
    .sub_count    (sub_count),
    .period_limit (period_limit),
    .duty_live    (duty_live),
    .pwm_out      (pwm_out)
  );

endmodule

// File: include/tbpwm_consts.vh
/*
 * Constants of the ten-bit PWM channel: register offsets, field
 * positions, reset values and AXI4-Lite response codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef TBPWM_CONSTS_VH
`define TBPWM_CONSTS_VH

`define TBPWM_AW          4
`define TBPWM_OFF_CTRL    4'h0
`define TBPWM_OFF_DCH     4'h4
`define TBPWM_OFF_DCL     4'h8

`define TBPWM_SEL_CTRL    2'h0
`define TBPWM_SEL_DCH     2'h1
`define TBPWM_SEL_DCL     2'h2
`define TBPWM_SEL_NONE    2'h3

`define TBPWM_EN_BIT      7
`define TBPWM_OUT_BIT     5
`define TBPWM_POL_BIT     4
`define TBPWM_DCL_HI      7
`define TBPWM_DCL_LO      6

`define TBPWM_DUTY_W      10
`define TBPWM_DUTY_ZERO   10'h000
`define TBPWM_BIT_CLR     1'h0
`define TBPWM_BIT_SET     1'h1
`define TBPWM_BYTE_ZERO   8'h00
`define TBPWM_PAD         24'h000000
`define TBPWM_WORD_ZERO   32'h00000000

`define TBPWM_RESP_OKAY   2'h0
`define TBPWM_RESP_SLVERR 2'h2

`endif

// File: src/tbpwm_dbuf.v
/*
 * Compare buffer for the duty value: copies the two software duty
 * registers into the buffer on each period match.
 * Assumes period_match is a one-cycle pulse on core_clk.
 */
`timescale 1ns/100ps
`include "tbpwm_consts.vh"

module tbpwm_dbuf (
  input  wire                      core_clk,
  input  wire [7:0]                duty_high,
  input  wire [1:0]                duty_low,
  input  wire                      period_match,
  output wire [`TBPWM_DUTY_W-1:0]  duty_live
);

  reg  [`TBPWM_DUTY_W-1:0] duty_buf_reg;
  wire [`TBPWM_DUTY_W-1:0] duty_buf_next;

  assign duty_buf_next = {duty_high, duty_low};

  // no reset: buffer keeps its value through a reset
  always @(posedge core_clk) begin
    if (period_match) begin
      duty_buf_reg <= duty_buf_next;
    end
  end

  // value seen by a clear in the same cycle as the reload
  assign duty_live = period_match ? duty_buf_next : duty_buf_reg;

endmodule

// File: src/tbpwm_wave.v
/*
 * Waveform generator: sets the wave at timer clear for a nonzero duty, ends it at the
 * duty match unless the duty reaches the period limit, applies polarity and registers the channel output.
 * Assumes timer signals come from logic on core_clk.
 */
`timescale 1ns/100ps
`include "tbpwm_consts.vh"

module tbpwm_wave (
  input  wire                      core_clk,
  input  wire                      reset,
  input  wire                      enable,
  input  wire                      invert,
  input  wire                      timer_clear,
  input  wire [7:0]                base_timer,
  input  wire [1:0]                sub_count,
  input  wire [7:0]                period_limit,
  input  wire [`TBPWM_DUTY_W-1:0]  duty_live,
  output reg                       pwm_out
);

  reg                      wave_reg;
  reg                      wave_next;
  wire [`TBPWM_DUTY_W-1:0] ext_count;
  wire                     full_duty;

  assign ext_count = {base_timer, sub_count};
  assign full_duty = (duty_live[`TBPWM_DUTY_W-1:2] >= period_limit);

  always @* begin
    wave_next = wave_reg;
    if (!enable) begin
      wave_next = `TBPWM_BIT_CLR;
    end else if (timer_clear) begin
      wave_next = (duty_live != `TBPWM_DUTY_ZERO);
    end else if ((ext_count == duty_live) && !full_duty) begin
      wave_next = `TBPWM_BIT_CLR;
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      wave_reg <= `TBPWM_BIT_CLR;
      pwm_out  <= `TBPWM_BIT_CLR;
    end else begin
      wave_reg <= wave_next;
      pwm_out  <= wave_next ^ invert;
    end
  end

endmodule

// File: dv/tbpwm_props.sv
/* checker of the pwm channel ports and register bus.
   assumes binding into tbpwm_top; reads and writes never overlap. */
`timescale 1ns/100ps
module tbpwm_props (
  input logic        core_clk,
  input logic        reset,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [3:0]  s_axi_awaddr,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0]  s_axi_wstrb,
  input logic        s_axi_bvalid,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [3:0]  s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic [7:0]  base_timer,
  input logic [1:0]  sub_count,
  input logic [7:0]  period_limit,
  input logic        timer_clear,
  input logic        period_match,
  input logic        pwm_out
);
  reg  [3:0] a_q, r_q;
  reg  [7:0] d_q, dh_s;
  reg  [1:0] dl_s;
  reg  [9:0] buf_s;
  reg        s_q, ha, hw, en_s, inv_s, out_q;
  wire       wr = ha && hw;
  wire [9:0] cnt = {base_timer, sub_count};
  wire       w_map = a_q == 4'h0 || a_q == 4'h4 || a_q == 4'h8;
  wire       r_map = r_q == 4'h0 || r_q == 4'h4 || r_q == 4'h8;
  wire [7:0] rd_exp = r_q == 4'h0 ? {en_s, 1'h0, out_q, inv_s, 4'h0}
                    : r_q == 4'h4 ? dh_s : r_q == 4'h8 ? {dl_s, 6'h00} : 8'h00;
  // shadow registers, written on the same edge as the design's
  always @(posedge core_clk) begin
    out_q <= pwm_out;
    if (period_match)
      buf_s <= {dh_s, dl_s};
    if (reset) begin
      ha <= 1'h0;
      hw <= 1'h0;
      en_s <= 1'h0;
      inv_s <= 1'h0;
    end else begin
      if (wr) begin
        ha <= 1'h0;
        hw <= 1'h0;
        if (s_q && a_q == 4'h0) {en_s, inv_s} <= {d_q[7], d_q[4]};
        if (s_q && a_q == 4'h4) dh_s <= d_q;
        if (s_q && a_q == 4'h8) dl_s <= d_q[7:6];
      end
      if (s_axi_awvalid && s_axi_awready) begin
        a_q <= s_axi_awaddr;
        ha <= 1'h1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        d_q <= s_axi_wdata[7:0];
        s_q <= s_axi_wstrb[0];
        hw <= 1'h1;
      end
      if (s_axi_arvalid && s_axi_arready)
        r_q <= s_axi_araddr;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_out_dis; !en_s && !$past(wr) |-> pwm_out == inv_s; endproperty
  a_out_dis: assert property (p_out_dis) else $error("disabled output level");
  property p_rd;
    $rose(s_axi_rvalid) |-> s_axi_rdata == {24'h000000, rd_exp} && s_axi_rresp == (r_map ? 2'h0 : 2'h2);
  endproperty
  a_rd: assert property (p_rd) else $error("read data");
  property p_bresp; $rose(s_axi_bvalid) |-> s_axi_bresp == (w_map ? 2'h0 : 2'h2); endproperty
  a_bresp: assert property (p_bresp) else $error("write response");
  property p_set; timer_clear && en_s && buf_s != 10'h000 && !wr |=> pwm_out == !inv_s; endproperty
  a_set: assert property (p_set) else $error("no set at clear");
  property p_zero; timer_clear && buf_s == 10'h000 && !wr |=> pwm_out == inv_s; endproperty
  a_zero: assert property (p_zero) else $error("zero duty set");
  property p_full;
    en_s && buf_s[9:2] >= period_limit && pwm_out != inv_s && !wr && !$past(wr) |=> pwm_out != inv_s;
  endproperty
  a_full: assert property (p_full) else $error("full duty cleared");
  property p_clr;
    en_s && !timer_clear && cnt == buf_s && buf_s[9:2] < period_limit && !wr |=> pwm_out == inv_s;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear at match");
  property p_hold;
    en_s && !timer_clear && cnt != buf_s && !wr && !$past(wr) |=> $stable(pwm_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved");
endmodule

bind tbpwm_top tbpwm_props tbpwm_props_i (
  .core_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
  .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .base_timer,
  .sub_count, .period_limit, .timer_clear, .period_match, .pwm_out
);

// File: dv/tbpwm_timer_model.sv
/* base timer model: ten-bit count with clear and match pulses.
   assumes a steady period limit from the bench. */
`timescale 1ns/100ps
module tbpwm_timer_model (
  input  wire       core_clk,
  input  wire       reset,
  input  wire [7:0] period_limit,
  output wire [7:0] base_timer,
  output wire [1:0] sub_count,
  output wire       timer_clear,
  output wire       period_match
);
  reg [9:0] cnt_reg;
  assign base_timer = cnt_reg[9:2];
  assign sub_count = cnt_reg[1:0];
  assign period_match = base_timer == period_limit && sub_count == 2'h3;
  assign timer_clear = cnt_reg == 10'h000;
  always @(posedge core_clk) begin
    if (reset || period_match)
      cnt_reg <= 10'h000;
    else
      cnt_reg <= cnt_reg + 10'h001;
  end
endmodule

// File: dv/tb_tbpwm_top.sv
/* self-checking bench of the pwm channel over the register bus.
   assumes the timer model with a period limit of 7, 32 cycles. */
`timescale 1ns/100ps
module tb_tbpwm_top;
  reg         core_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  reg  [2:0]  s_axi_awprot, s_axi_arprot;
  reg  [31:0] s_axi_wdata;
  reg  [7:0]  period_limit;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, sub_count;
  wire [31:0] s_axi_rdata;
  wire [7:0]  base_timer;
  wire        timer_clear, period_match, pwm_out;
  integer     n_fail, tests_run, i, j, k, e;
  reg  [1:0]  r;
  reg  [9:0]  d;
  tbpwm_top tbpwm_top_i (.core_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .base_timer, .sub_count,
    .period_limit, .timer_clear, .period_match, .pwm_out);
  tbpwm_timer_model tbpwm_timer_model_i (.core_clk, .reset, .period_limit, .base_timer,
    .sub_count, .timer_clear, .period_match);
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v, input [3:0] s);
    reg b;
    begin
      b = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!b) begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid) begin
          b = 1;
          r = s_axi_bresp;
          s_axi_bready <= 1'h0;
        end
      end
    end
  endtask
  task rc(input string nm, input [3:0] a, input [31:0] ev, input [1:0] er);
    reg b;
    begin
      b = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!b) begin
        @(posedge core_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid) begin
          b = 1;
          chk(nm, s_axi_rdata, ev);
          chk(nm, {30'h00000000, s_axi_rresp}, {30'h00000000, er});
          s_axi_rready <= 1'h0;
        end
      end
    end
  endtask
  // active cycles over one period after a timer clear
  task meas(output integer n, input inv);
    begin
      n = 0;
      @(posedge core_clk);
      while (!timer_clear) @(posedge core_clk);
      repeat (32) begin
        @(posedge core_clk);
        if (pwm_out === !inv) n = n + 1;
      end
    end
  endtask
  task finish_test;
    begin
      if (n_fail == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    n_fail = n_fail + 1;
    finish_test;
  end
  initial begin
    {n_fail, tests_run} = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    period_limit = 8'h07;
    reset = 1;
    repeat (8) @(posedge core_clk);
    reset <= 1'h0;
    rc("ctrl", 4'h0, 32'h0, 2'h0);
    rc("hole", 4'hC, 32'h0, 2'h2);
    wr(4'hC, 8'hFF, 4'hF);
    chk("wresp", r, 2'h2);
    wr(4'h4, 8'hA5, 4'h1);
    wr(4'h8, 8'hFF, 4'h1);
    rc("dch", 4'h4, 32'hA5, 2'h0);
    rc("dcl", 4'h8, 32'hC0, 2'h0);
    wr(4'h0, 8'h5F, 4'h1);
    rc("ctrl", 4'h0, 32'h30, 2'h0);
    wr(4'h0, 8'h80, 4'h0);
    rc("strb", 4'h0, 32'h30, 2'h0);
    for (i = 0; i < 4; i = i + 1) begin
      d = i == 0 ? 10'h000 : i == 1 ? 10'h001 : i == 2 ? 10'h01B : 10'h01C;
      e = d == 10'h000 ? 0 : d[9:2] >= 8'h07 ? 32 : d;
      wr(4'h4, d[9:2], 4'h1);
      wr(4'h8, {d[1:0], 6'h3F}, 4'h1);
      for (j = 0; j < 3; j = j + 1) begin
        wr(4'h0, {j < 2, 2'h0, j[0], 4'hF}, 4'h1);
        meas(k, j[0]);
        meas(k, j[0]);
        chk("active", k, j < 2 ? e : 0);
      end
    end
    wr(4'h0, 8'h90, 4'h1);
    @(posedge core_clk);
    reset <= 1'h1;
    repeat (2) @(posedge core_clk);
    reset <= 1'h0;
    rc("ctrl", 4'h0, 32'h0, 2'h0);
    rc("dch", 4'h4, 32'h07, 2'h0);
    finish_test;
  end
endmodule
